// *** core/meter_cfg_map.svh ***
`ifndef METER_CFG_MAP_SVH
`define METER_CFG_MAP_SVH
// Overview of operation
// - writing one to config-one bit 7 returns all energy registers to defaults
// - config-one bit 6 bypasses the zero-crossing low-pass filter
// - config-one bit 5 inserts the di/dt integrator in the current path
// - config-one bit 4 exchanges the roles of ADC channels one and two
// - config-one bit 3 holds both voltage and current ADCs powered down
// - config-one bit 2, reset one, disables pulse output B
// - config-one bit 1, reset one, disables pulse output A
// - config-one bit 0 bypasses high-pass filters in both channels
// - config-two bits 7:6 pick pulse B source, reset 01 reactive
// - config-two bits 5:4 pick pulse A source, reset 00 active
// - config-two bit 3 picks apparent (0) or rms current (1) for 1X
// - config-two bit 2 makes rms results update only on voltage crossings
// - config-two bit 1 picks period (0) or frequency (1) line value
// - config-two bit 0 enables waveform sampling mode
// - pulse B numerator 16 bits reset 0, denominator 16 bits reset 0x003F
// - register 0x2B holds crossing output enables, reset zero
// - register 0x3D holds calibration mode selection, reset zero

// register indexes; byte address is four times the index
`define IDX_CFG_ONE 7'h0B
`define IDX_CFG_TWO 7'h0C
`define IDX_B_NUM 7'h29
`define IDX_B_DEN 7'h2A
`define IDX_XING 7'h2B
`define IDX_RSVD_A 7'h3B
`define IDX_RSVD_B 7'h3C
`define IDX_CAL 7'h3D
`define IDX_RSVD_C 7'h3E
`define IDX_RSVD_D 7'h3F

`define RST_CFG_ONE 8'h06
`define RST_CFG_TWO 8'h40
`define RST_B_NUM 16'h0000
`define RST_B_DEN 16'h003F
`define RST_XING 8'h00
`define RST_RSVD_A 8'h00
`define RST_RSVD_B 16'h0300
`define RST_CAL 8'h00
`define RST_RSVD_C 8'h00
`define RST_RSVD_D 8'h00

// config-one bits
`define B1_SOFT_RST 7
`define B1_ZX_BYP 6
`define B1_DIDT 5
`define B1_EXCH 4
`define B1_SLEEP 3
`define B1_B_OFF 2
`define B1_A_OFF 1
`define B1_DC_BYP 0
// config-two fields
`define B2_B_SRC_HI 7
`define B2_B_SRC_LO 6
`define B2_A_SRC_HI 5
`define B2_A_SRC_LO 4
`define B2_PICK 3
`define B2_ZX_RMS 2
`define B2_RATE 1
`define B2_WAVE 0
`endif

// *** core/meter_cfg_pkg.sv ***
`default_nettype none
package meter_cfg_pkg;
   typedef logic [6:0] reg_idx_t;
   typedef enum logic [1:0] {
      SRC_ACTIVE,
      SRC_REACTIVE,
      SRC_APPARENT,
      SRC_CURRENT
   } pulse_src_t;

   // 1X fields share one pick bit, so both outputs follow the same choice
   function automatic pulse_src_t src_of(input logic [1:0] field, input logic pick);
      if (field[1]) begin
         return pick ? SRC_CURRENT : SRC_APPARENT;
      end
      return field[0] ? SRC_REACTIVE : SRC_ACTIVE;
   endfunction
endpackage
`default_nettype wire

// *** core/meter_mode_config.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_map.svh"
module meter_mode_config #(
   parameter int ADDR_W = 9,
   parameter int SAMPLE_W = 24
) (
   input wire logic CLK_I,                    // core clock, 250 MHz
   input wire logic RST_I,                    // async reset, high
   input wire logic PSEL_I,                   // apb select
   input wire logic PENABLE_I,                // apb access phase
   input wire logic PWRITE_I,                 // apb direction
   input wire logic [ADDR_W-1:0] PADDR_I,     // apb byte address
   input wire logic [31:0] PWDATA_I,          // apb write data
   input wire logic [3:0] PSTRB_I,            // apb byte lanes
   output logic [31:0] PRDATA_O,              // apb read data
   output logic PREADY_O,                     // apb ready
   output logic PSLVERR_O,                    // unmapped access
   output logic ENERGY_RST_O,                 // soft reset pulse
   output logic ZX_FILTER_BYPASS_O,           // crossing lpf off
   output logic DIDT_ACCUMULATE_ON_O,         // integrator in path
   output logic ADC_CHANNEL_EXCHANGE_O,       // channels swapped
   output logic ADC_SLEEP_O,                  // adcs powered down
   output logic DC_REMOVAL_BYPASS_O,          // hpfs off
   output meter_cfg_pkg::pulse_src_t PULSE_OUT_A_SOURCE_O, // pulse A source
   output meter_cfg_pkg::pulse_src_t PULSE_OUT_B_SOURCE_O, // pulse B source
   output logic RMS_UPDATE_ON_CROSSING_O,     // rms held to crossings
   output logic PERIOD_OR_RATE_PICK_O,        // 1 = frequency
   output logic WAVEFORM_CAPTURE_ON_O,        // waveform mode
   output logic [15:0] PULSE_B_NUMERATOR_O,   // pulse B numerator
   output logic [15:0] PULSE_B_DENOMINATOR_O, // pulse B denominator
   output logic [7:0] CROSSING_OUTPUT_CONFIG_O, // crossing enables
   output logic [7:0] CALIBRATION_SELECT_O,   // calibration mode
   input wire logic [SAMPLE_W-1:0] ADC_CHANNEL_ONE_I, // channel one sample
   input wire logic [SAMPLE_W-1:0] ADC_CHANNEL_TWO_I, // channel two sample
   input wire logic ADC_VALID_I,              // samples valid pulse
   output logic [SAMPLE_W-1:0] CURR_SAMPLE_O, // current path sample
   output logic [SAMPLE_W-1:0] VOLT_SAMPLE_O, // voltage path sample
   output logic SAMPLE_VALID_O,               // samples valid pulse
   input wire logic [3:0] PULSE_RAW_I,        // raw pulses by source
   output logic PULSE_OUT_A_O,                // frequency output A
   output logic PULSE_OUT_B_O,                // frequency output B
   input wire logic RMS_READY_I,              // new rms result
   input wire logic VOLT_CROSSING_I,          // voltage zero crossing
   output logic RMS_UPDATE_O,                 // rms register load
   input wire logic [15:0] LINE_PERIOD_I,     // measured period
   input wire logic [15:0] LINE_RATE_I,       // measured frequency
   output logic [15:0] LINE_PERIOD_VALUE_O    // line period register
);
   import meter_cfg_pkg::*;

   logic [7:0] cfg_one_r;
   logic [7:0] cfg_two_r;
   logic [15:0] b_num_r;
   logic [15:0] b_den_r;
   logic [7:0] xing_r;
   logic [7:0] rsvd_a_r;
   logic [15:0] rsvd_b_r;
   logic [7:0] cal_r;
   logic [7:0] rsvd_c_r;
   logic [7:0] rsvd_d_r;
   logic [31:0] rdata_nxt;
   logic soft_rst_r;
   reg_idx_t idx;
   logic aligned;
   logic mapped;
   logic setup;
   logic access;
   logic wr;
   logic soft_rst;
   logic high_zero;

   function automatic logic is_mapped(input reg_idx_t i);
      unique case (i)
         `IDX_CFG_ONE, `IDX_CFG_TWO, `IDX_B_NUM, `IDX_B_DEN, `IDX_XING,
         `IDX_RSVD_A, `IDX_RSVD_B, `IDX_CAL, `IDX_RSVD_C, `IDX_RSVD_D: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction

   // byte lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   function automatic logic write_hit(input reg_idx_t want, input reg_idx_t got,
                                      input logic w, input logic lane);
      return w && lane && (want == got);
   endfunction

   // index sits in address bits 8:2; higher bits or a misaligned address map nothing
   assign idx = reg_idx_t'(PADDR_I[8:2]);
   assign aligned = (PADDR_I[1:0] == 2'b00);
   // a wider address bus must not alias the register map
   assign high_zero = ((PADDR_I >> 9) == '0);
   assign mapped = aligned && high_zero && is_mapped(idx);
   assign setup = PSEL_I && !PENABLE_I;
   assign access = PSEL_I && PENABLE_I;
   assign wr = access && PWRITE_I && mapped;
   assign soft_rst = write_hit(`IDX_CFG_ONE, idx, wr, PSTRB_I[0])
                     && PWDATA_I[`B1_SOFT_RST];

   // zero-wait slave: every access completes in its first access cycle
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = access && !mapped;

   // soft reset wins over the write that carries it, so bit 7 never reads back as one
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg_one_r <= `RST_CFG_ONE;
      end else if (soft_rst) begin
         cfg_one_r <= `RST_CFG_ONE;
      end else if (write_hit(`IDX_CFG_ONE, idx, wr, PSTRB_I[0])) begin
         cfg_one_r <= {1'b0, PWDATA_I[6:0]};
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg_two_r <= `RST_CFG_TWO;
      end else if (soft_rst) begin
         cfg_two_r <= `RST_CFG_TWO;
      end else if (write_hit(`IDX_CFG_TWO, idx, wr, PSTRB_I[0])) begin
         cfg_two_r <= PWDATA_I[7:0];
      end
   end

   // 16-bit registers take each byte lane on its own
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         b_num_r <= `RST_B_NUM;
      end else if (soft_rst) begin
         b_num_r <= `RST_B_NUM;
      end else if (wr && idx == `IDX_B_NUM) begin
         b_num_r <= merge16(b_num_r, PWDATA_I, PSTRB_I);
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         b_den_r <= `RST_B_DEN;
      end else if (soft_rst) begin
         b_den_r <= `RST_B_DEN;
      end else if (wr && idx == `IDX_B_DEN) begin
         b_den_r <= merge16(b_den_r, PWDATA_I, PSTRB_I);
      end
   end

   // 8-bit registers need lane 0; upper lanes are dropped
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         xing_r <= `RST_XING;
      end else if (soft_rst) begin
         xing_r <= `RST_XING;
      end else if (write_hit(`IDX_XING, idx, wr, PSTRB_I[0])) begin
         xing_r <= PWDATA_I[7:0];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cal_r <= `RST_CAL;
      end else if (soft_rst) begin
         cal_r <= `RST_CAL;
      end else if (write_hit(`IDX_CAL, idx, wr, PSTRB_I[0])) begin
         cal_r <= PWDATA_I[7:0];
      end
   end

   // reserved slots store what is written; other than default is unsupported
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rsvd_a_r <= `RST_RSVD_A;
      end else if (soft_rst) begin
         rsvd_a_r <= `RST_RSVD_A;
      end else if (write_hit(`IDX_RSVD_A, idx, wr, PSTRB_I[0])) begin
         rsvd_a_r <= PWDATA_I[7:0];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rsvd_b_r <= `RST_RSVD_B;
      end else if (soft_rst) begin
         rsvd_b_r <= `RST_RSVD_B;
      end else if (wr && idx == `IDX_RSVD_B) begin
         rsvd_b_r <= merge16(rsvd_b_r, PWDATA_I, PSTRB_I);
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rsvd_c_r <= `RST_RSVD_C;
      end else if (soft_rst) begin
         rsvd_c_r <= `RST_RSVD_C;
      end else if (write_hit(`IDX_RSVD_C, idx, wr, PSTRB_I[0])) begin
         rsvd_c_r <= PWDATA_I[7:0];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rsvd_d_r <= `RST_RSVD_D;
      end else if (soft_rst) begin
         rsvd_d_r <= `RST_RSVD_D;
      end else if (write_hit(`IDX_RSVD_D, idx, wr, PSTRB_I[0])) begin
         rsvd_d_r <= PWDATA_I[7:0];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= soft_rst;
      end
   end
   assign ENERGY_RST_O = soft_rst_r;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (aligned && high_zero) begin
         unique case (idx)
            `IDX_CFG_ONE: rdata_nxt[7:0] = cfg_one_r;
            `IDX_CFG_TWO: rdata_nxt[7:0] = cfg_two_r;
            `IDX_B_NUM: rdata_nxt[15:0] = b_num_r;
            `IDX_B_DEN: rdata_nxt[15:0] = b_den_r;
            `IDX_XING: rdata_nxt[7:0] = xing_r;
            `IDX_RSVD_A: rdata_nxt[7:0] = rsvd_a_r;
            `IDX_RSVD_B: rdata_nxt[15:0] = rsvd_b_r;
            `IDX_CAL: rdata_nxt[7:0] = cal_r;
            `IDX_RSVD_C: rdata_nxt[7:0] = rsvd_c_r;
            `IDX_RSVD_D: rdata_nxt[7:0] = rsvd_d_r;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // read data is captured in the setup cycle and stands through the access cycle
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (setup && !PWRITE_I) begin
         PRDATA_O <= rdata_nxt;
      end
   end

   assign ZX_FILTER_BYPASS_O = cfg_one_r[`B1_ZX_BYP];
   assign DIDT_ACCUMULATE_ON_O = cfg_one_r[`B1_DIDT];
   assign ADC_CHANNEL_EXCHANGE_O = cfg_one_r[`B1_EXCH];
   assign ADC_SLEEP_O = cfg_one_r[`B1_SLEEP];
   assign DC_REMOVAL_BYPASS_O = cfg_one_r[`B1_DC_BYP];
   assign PULSE_OUT_B_SOURCE_O = src_of(cfg_two_r[`B2_B_SRC_HI:`B2_B_SRC_LO],
                                        cfg_two_r[`B2_PICK]);
   assign PULSE_OUT_A_SOURCE_O = src_of(cfg_two_r[`B2_A_SRC_HI:`B2_A_SRC_LO],
                                        cfg_two_r[`B2_PICK]);
   assign RMS_UPDATE_ON_CROSSING_O = cfg_two_r[`B2_ZX_RMS];
   assign PERIOD_OR_RATE_PICK_O = cfg_two_r[`B2_RATE];
   assign WAVEFORM_CAPTURE_ON_O = cfg_two_r[`B2_WAVE];
   assign PULSE_B_NUMERATOR_O = b_num_r;
   assign PULSE_B_DENOMINATOR_O = b_den_r;
   assign CROSSING_OUTPUT_CONFIG_O = xing_r;
   assign CALIBRATION_SELECT_O = cal_r;

   // channel one carries current and channel two voltage unless exchanged;
   // while asleep the samples read zero and no valid pulse is passed on
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CURR_SAMPLE_O <= '0;
         VOLT_SAMPLE_O <= '0;
         SAMPLE_VALID_O <= 1'b0;
      end else if (cfg_one_r[`B1_SLEEP]) begin
         CURR_SAMPLE_O <= '0;
         VOLT_SAMPLE_O <= '0;
         SAMPLE_VALID_O <= 1'b0;
      end else begin
         SAMPLE_VALID_O <= ADC_VALID_I;
         if (ADC_VALID_I) begin
            if (cfg_one_r[`B1_EXCH]) begin
               CURR_SAMPLE_O <= ADC_CHANNEL_TWO_I;
               VOLT_SAMPLE_O <= ADC_CHANNEL_ONE_I;
            end else begin
               CURR_SAMPLE_O <= ADC_CHANNEL_ONE_I;
               VOLT_SAMPLE_O <= ADC_CHANNEL_TWO_I;
            end
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         LINE_PERIOD_VALUE_O <= 16'h0000;
      end else if (cfg_two_r[`B2_RATE]) begin
         LINE_PERIOD_VALUE_O <= LINE_RATE_I;
      end else begin
         LINE_PERIOD_VALUE_O <= LINE_PERIOD_I;
      end
   end

   pulse_out_gate gate_a (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .off_i(cfg_one_r[`B1_A_OFF]),
      .src_i(PULSE_OUT_A_SOURCE_O),
      .raw_i(PULSE_RAW_I),
      .pulse_o(PULSE_OUT_A_O)
   );

   pulse_out_gate gate_b (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .off_i(cfg_one_r[`B1_B_OFF]),
      .src_i(PULSE_OUT_B_SOURCE_O),
      .raw_i(PULSE_RAW_I),
      .pulse_o(PULSE_OUT_B_O)
   );

   rms_update_gate rms_gate (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .on_crossing_i(cfg_two_r[`B2_ZX_RMS]),
      .ready_i(RMS_READY_I),
      .crossing_i(VOLT_CROSSING_I),
      .update_o(RMS_UPDATE_O)
   );
endmodule
`default_nettype wire

// *** core/pulse_out_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module pulse_out_gate (
   input wire logic CLK_I,                        // core clock
   input wire logic RST_I,                        // async reset, high
   input wire logic off_i,                        // output disabled
   input wire meter_cfg_pkg::pulse_src_t src_i,   // chosen source
   input wire logic [3:0] raw_i,                  // raw pulses by source
   output logic pulse_o                           // gated pulse
);
   import meter_cfg_pkg::*;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= !off_i && raw_i[src_i];
      end
   end
endmodule
`default_nettype wire

// *** core/rms_update_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module rms_update_gate (
   input wire logic CLK_I,         // core clock
   input wire logic RST_I,         // async reset, high
   input wire logic on_crossing_i, // hold updates for crossings
   input wire logic ready_i,       // new rms result pulse
   input wire logic crossing_i,    // voltage zero crossing pulse
   output logic update_o           // rms register load pulse
);
   logic pending_r;

   // a result that lands while waiting is kept until the next crossing
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pending_r <= 1'b0;
         update_o <= 1'b0;
      end else if (!on_crossing_i) begin
         pending_r <= 1'b0;
         update_o <= ready_i;
      end else if (crossing_i && (pending_r || ready_i)) begin
         pending_r <= 1'b0;
         update_o <= 1'b1;
      end else begin
         pending_r <= pending_r || ready_i;
         update_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** testbench/meter_mode_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_map.svh"
module meter_mode_monitor #(
   parameter int ADDR_W = 9,
   parameter int SAMPLE_W = 24
) (
   input wire logic CLK_I, // clock
   input wire logic RST_I, // reset
   input wire logic PSEL_I, // select
   input wire logic PENABLE_I, // access
   input wire logic PWRITE_I, // direction
   input wire logic [ADDR_W-1:0] PADDR_I, // address
   input wire logic [31:0] PWDATA_I, // write data
   input wire logic [3:0] PSTRB_I, // lanes
   input wire logic PREADY_O, // ready
   input wire logic PSLVERR_O, // error
   input wire logic ENERGY_RST_O, // soft reset
   input wire logic ADC_SLEEP_O, // adcs down
   input wire logic SAMPLE_VALID_O, // sample valid
   input wire meter_cfg_pkg::pulse_src_t PULSE_OUT_A_SOURCE_O, // source a
   input wire meter_cfg_pkg::pulse_src_t PULSE_OUT_B_SOURCE_O, // source b
   input wire logic [15:0] PULSE_B_NUMERATOR_O, // numerator
   input wire logic [15:0] PULSE_B_DENOMINATOR_O, // denominator
   input wire logic PERIOD_OR_RATE_PICK_O, // rate pick
   input wire logic [15:0] LINE_PERIOD_I, // period
   input wire logic [15:0] LINE_RATE_I, // rate
   input wire logic [15:0] LINE_PERIOD_VALUE_O, // line value
   input wire logic RMS_UPDATE_ON_CROSSING_O, // rms held
   input wire logic RMS_READY_I, // rms ready
   input wire logic VOLT_CROSSING_I, // crossing
   input wire logic RMS_UPDATE_O // rms load
);
   import meter_cfg_pkg::*;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_soft_reset: assert property (
      PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == {`IDX_CFG_ONE, 2'b00} && PSTRB_I[0]
      && PWDATA_I[7] |=> ENERGY_RST_O && PULSE_B_DENOMINATOR_O == 16'h003F
      && PULSE_B_NUMERATOR_O == 16'h0000) else $error("soft reset did not restore");
   a_rst_pulse: assert property (ENERGY_RST_O |=> !ENERGY_RST_O)
      else $error("soft reset pulse too long");
   a_num_write: assert property (
      PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == {`IDX_B_NUM, 2'b00} && PSTRB_I[1:0] == 2'b11
      |=> {16'h0000, PULSE_B_NUMERATOR_O} == ($past(PWDATA_I) & 32'h0000_FFFF))
      else $error("numerator write lost");
   a_unmapped_err: assert property (
      PSEL_I && PENABLE_I && PADDR_I[ADDR_W-1:2] == 7'h00 |-> PSLVERR_O && PREADY_O)
      else $error("unmapped access not flagged");
   a_sleep_quiet: assert property (ADC_SLEEP_O |=> !SAMPLE_VALID_O)
      else $error("sample valid while asleep");
   a_shared_pick: assert property (
      PULSE_OUT_A_SOURCE_O[1] && PULSE_OUT_B_SOURCE_O[1]
      |-> PULSE_OUT_A_SOURCE_O == PULSE_OUT_B_SOURCE_O) else $error("pick not shared");
   a_line_pick: assert property (!RST_I |=> LINE_PERIOD_VALUE_O ==
      ($past(PERIOD_OR_RATE_PICK_O) ? $past(LINE_RATE_I) : $past(LINE_PERIOD_I)))
      else $error("line value wrong source");
   a_rms_direct: assert property (
      !RMS_UPDATE_ON_CROSSING_O |=> RMS_UPDATE_O == $past(RMS_READY_I))
      else $error("rms update not direct");
   a_rms_hold: assert property (
      RMS_UPDATE_ON_CROSSING_O && !VOLT_CROSSING_I |=> !RMS_UPDATE_O)
      else $error("rms update without crossing");
endmodule
bind meter_mode_config meter_mode_monitor #(.ADDR_W(ADDR_W), .SAMPLE_W(SAMPLE_W)) u_monitor (
   .CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I,
   .PREADY_O, .PSLVERR_O, .ENERGY_RST_O, .ADC_SLEEP_O, .SAMPLE_VALID_O,
   .PULSE_OUT_A_SOURCE_O, .PULSE_OUT_B_SOURCE_O, .PULSE_B_NUMERATOR_O,
   .PULSE_B_DENOMINATOR_O, .PERIOD_OR_RATE_PICK_O, .LINE_PERIOD_I, .LINE_RATE_I,
   .LINE_PERIOD_VALUE_O, .RMS_UPDATE_ON_CROSSING_O, .RMS_READY_I, .VOLT_CROSSING_I,
   .RMS_UPDATE_O
);
`default_nettype wire

// *** testbench/tb_meter_mode_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_meter_mode_config;
   import meter_cfg_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [8:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = '0, raw = '0;
   logic pready, pslverr, er, erst, zxb, didt, exch, sleep, dcb, rmson, pick, wave;
   logic avalid = 1'b0, svalid, pa, pb, rrdy = 1'b0, vx = 1'b0, rupd;
   pulse_src_t asrc, bsrc, ea, eb;
   logic [15:0] num, den, lval, lper = 16'h1234, lrate = 16'h0032;
   logic [7:0] xing, cal;
   logic [23:0] adc_one = 24'hA1_B2C3, adc_two = 24'h5D_6E7F, curr, volt;
   int err_count = 0, checks_done = 0;
   logic [6:0] idx_tbl [10] = '{7'h0B, 7'h0C, 7'h29, 7'h2A, 7'h2B, 7'h3B, 7'h3C, 7'h3D,
      7'h3E, 7'h3F};
   logic [15:0] rst_tbl [10] = '{16'h0006, 16'h0040, 16'h0000, 16'h003F, 16'h0000,
      16'h0000, 16'h0300, 16'h0000, 16'h0000, 16'h0000};
   always #2 clk = ~clk;
   meter_mode_config #(.ADDR_W(9), .SAMPLE_W(24)) dut (
      .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .ENERGY_RST_O(erst),
      .ZX_FILTER_BYPASS_O(zxb), .DIDT_ACCUMULATE_ON_O(didt), .ADC_CHANNEL_EXCHANGE_O(exch),
      .ADC_SLEEP_O(sleep), .DC_REMOVAL_BYPASS_O(dcb), .PULSE_OUT_A_SOURCE_O(asrc),
      .PULSE_OUT_B_SOURCE_O(bsrc), .RMS_UPDATE_ON_CROSSING_O(rmson),
      .PERIOD_OR_RATE_PICK_O(pick), .WAVEFORM_CAPTURE_ON_O(wave),
      .PULSE_B_NUMERATOR_O(num), .PULSE_B_DENOMINATOR_O(den),
      .CROSSING_OUTPUT_CONFIG_O(xing), .CALIBRATION_SELECT_O(cal),
      .ADC_CHANNEL_ONE_I(adc_one), .ADC_CHANNEL_TWO_I(adc_two), .ADC_VALID_I(avalid),
      .CURR_SAMPLE_O(curr), .VOLT_SAMPLE_O(volt), .SAMPLE_VALID_O(svalid),
      .PULSE_RAW_I(raw), .PULSE_OUT_A_O(pa), .PULSE_OUT_B_O(pb), .RMS_READY_I(rrdy),
      .VOLT_CROSSING_I(vx), .RMS_UPDATE_O(rupd), .LINE_PERIOD_I(lper),
      .LINE_RATE_I(lrate), .LINE_PERIOD_VALUE_O(lval)
   );
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one apb transfer; the request is held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [6:0] idx, input logic [31:0] wd,
         input logic [3:0] strb);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      pstrb <= strb;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         check("pready", 32'(pready), 32'h0000_0001);
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [6:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0000_0000, 4'h0);
      check($sformatf("reg %h", idx), rd, exp);
   endtask
   task automatic chk_defaults();
      for (int i = 0; i < 10; i++) begin
         rd_chk(idx_tbl[i], {16'h0000, rst_tbl[i]});
      end
   endtask
   task automatic sample(input logic [23:0] ec, input logic [23:0] ev, input logic ex);
      @(posedge clk);
      avalid <= 1'b1;
      @(posedge clk);
      avalid <= 1'b0;
      #1;
      check("curr", 32'(curr), 32'(ec));
      check("volt", 32'(volt), 32'(ev));
      check("svalid", 32'(svalid), 32'(ex));
   endtask
   function automatic pulse_src_t want(input int fld, input int p);
      if (fld >= 2) begin
         return p ? SRC_CURRENT : SRC_APPARENT;
      end
      return pulse_src_t'(2'(fld));
   endfunction
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk_defaults();
      check("src", 32'({asrc, bsrc}), 32'h0000_0001);
      @(posedge clk);
      raw <= 4'hF;
      repeat (3) @(posedge clk);
      #1;
      check("pulses off", 32'({pa, pb}), 32'h0000_0000);
      xfer(1'b1, 7'h0B, 32'h0000_0079, 4'h1);
      #1;
      check("cfg1", 32'({zxb, didt, exch, sleep, dcb}), 32'h0000_001F);
      sample(24'h00_0000, 24'h00_0000, 1'b0);
      xfer(1'b1, 7'h0B, 32'h0000_0010, 4'h1);
      sample(adc_two, adc_one, 1'b1);
      xfer(1'b1, 7'h0B, 32'h0000_0000, 4'h1);
      sample(adc_one, adc_two, 1'b1);
      // fields differ between outputs so a crossed decode shows up
      for (int f = 0; f < 4; f++) begin
         for (int p = 0; p < 2; p++) begin
            ea = want(3 - f, p);
            eb = want(f, p);
            xfer(1'b1, 7'h0C, 32'((f << 6) | ((3 - f) << 4) | (p << 3)), 4'h1);
            #1;
            check("srcs", 32'({asrc, bsrc}), 32'({ea, eb}));
            @(posedge clk);
            raw <= 4'b0001 << ea;
            repeat (2) @(posedge clk);
            #1;
            check("pulse a", 32'({pa, pb}), 32'({1'b1, ea == eb}));
            @(posedge clk);
            raw <= 4'b0001 << eb;
            repeat (2) @(posedge clk);
            #1;
            check("pulse b", 32'({pa, pb}), 32'({ea == eb, 1'b1}));
         end
      end
      xfer(1'b1, 7'h0C, 32'h0000_0000, 4'h1);
      @(posedge clk);
      rrdy <= 1'b1;
      @(posedge clk);
      rrdy <= 1'b0;
      #1;
      check("rms direct", 32'(rupd), 32'h0000_0001);
      xfer(1'b1, 7'h0C, 32'h0000_0004, 4'h1);
      @(posedge clk);
      rrdy <= 1'b1;
      @(posedge clk);
      rrdy <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("rms held", 32'(rupd), 32'h0000_0000);
      @(posedge clk);
      vx <= 1'b1;
      @(posedge clk);
      vx <= 1'b0;
      #1;
      check("rms crossing", 32'(rupd), 32'h0000_0001);
      xfer(1'b1, 7'h0C, 32'h0000_0003, 4'h1);
      repeat (2) @(posedge clk);
      #1;
      check("wave line", 32'({wave, pick, lval}), 32'h0003_0032);
      xfer(1'b1, 7'h29, 32'h0000_BEEF, 4'h3);
      xfer(1'b1, 7'h2A, 32'h0000_1234, 4'h1);
      rd_chk(7'h2A, 32'h0000_0034);
      check("num", 32'(num), 32'h0000_BEEF);
      xfer(1'b1, 7'h2B, 32'h0000_00A5, 4'h1);
      xfer(1'b1, 7'h3D, 32'h0000_005A, 4'h1);
      rd_chk(7'h3D, 32'h0000_005A);
      check("xing cal", 32'({xing, cal}), 32'h0000_A55A);
      // 0x4C aliases the second config slot if the top index bit is dropped
      xfer(1'b1, 7'h4C, 32'h0000_00FF, 4'hF);
      check("slverr", 32'(er), 32'h0000_0001);
      rd_chk(7'h0C, 32'h0000_0003);
      rd_chk(7'h00, 32'h0000_0000);
      xfer(1'b1, 7'h0B, 32'h0000_0080, 4'h1);
      #1;
      check("soft reset", 32'(erst), 32'h0000_0001);
      chk_defaults();
      end_sim();
   end
endmodule
`default_nettype wire
